// ==== dbi_pkg.sv ====
/*
  Shared constants, types and line-coding functions for both agents of the
  quad-pumped data phase: group inversion, check bits, occupancy, postpone.
  Assumes both agents compile against this package and meet in dbi_link_if.
*/
// Function
// (RL1) four 16-bit groups, one inversion flag each
// (RL2) flag n covers data bits 16n+15..16n
// (RL3) receiver undoes inversion when group flag active
// (RL4) invert group when more than half low
// (RL5) flag active exactly when group driven inverted
// (RL6) flags travel with data, one per sub-phase
// (RL7) driver holds occupied while using the bus
// (RL8) start driving only after occupied is released
// (RL9) non-ordered completion raises postpone toward processor
// (RL10) addressed agent raises postpone, not bystanders
// (RL11) data driver also drives the check bits
// (RL12) 64-bit path, four sub-phases per bus clock; here one sub-phase per link clock period
// (RL13) exactly half low stays plain, flag inactive
package dbi_pkg;

  localparam int DATA_W   = 64;
  localparam int GROUP_W  = 16;
  localparam int GROUPS   = 4;
  localparam int BEATS    = 4;
  localparam int LINE_W   = DATA_W * BEATS;
  localparam int WIRE_W   = GROUPS + GROUPS + DATA_W;

  localparam logic [4:0] GROUP_HALF = 5'h08;
  localparam logic [1:0] BEAT_LAST  = 2'h3;
  localparam logic       LINE_LOW   = 1'b0;

  localparam int LINK_PERIOD_NS = 160;
  localparam int REF_PERIOD_NS  = 10;
  localparam int DIV_RATIO      = LINK_PERIOD_NS / REF_PERIOD_NS;
  localparam logic [3:0] DIV_LAST   = 4'(DIV_RATIO - 1);
  localparam logic [3:0] DIV_FALL   = 4'(DIV_RATIO / 2 - 1);
  localparam logic [3:0] LAUNCH_CNT = DIV_FALL;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_DRIVE   = 2'b01,
    ST_RELEASE = 2'b11
  } xfer_state_t;

  // electrical levels as they stand on the lines, low means asserted
  typedef struct packed {
    logic [GROUPS-1:0] flags;
    logic [GROUPS-1:0] check;
    logic [DATA_W-1:0] data;
  } wire_word_t;

  function automatic wire_word_t encode_word(input logic [DATA_W-1:0] word);
    wire_word_t         w;
    logic [GROUP_W-1:0] grp;
    logic [4:0]         ones;
    w = '1;
    for (int g = 0; g < GROUPS; g++) begin
      grp  = word[g*GROUP_W +: GROUP_W];
      ones = '0;
      for (int b = 0; b < GROUP_W; b++) begin
        ones = ones + 5'(grp[b]);
      end
      // a logical one pulls the line low; a tie at half stays plain
      if (ones > GROUP_HALF) begin
        w.data[g*GROUP_W +: GROUP_W] = grp;      // [RL4] [RL13]
        w.flags[g] = LINE_LOW;                   // [RL5]
      end else begin
        w.data[g*GROUP_W +: GROUP_W] = ~grp;
        w.flags[g] = ~LINE_LOW;
      end
      w.check[g] = ^w.data[g*GROUP_W +: GROUP_W];
    end
    return w;
  endfunction

  function automatic logic [DATA_W-1:0] decode_word(input wire_word_t w);
    logic [DATA_W-1:0] d;
    d = '0;
    for (int g = 0; g < GROUPS; g++) begin
      // [RL2] [RL3]
      d[g*GROUP_W +: GROUP_W] = (w.flags[g] == LINE_LOW) ?
                                w.data[g*GROUP_W +: GROUP_W] :
                                ~w.data[g*GROUP_W +: GROUP_W];
    end
    return d;
  endfunction

  function automatic logic check_fail(input wire_word_t w);
    logic bad;
    bad = 1'b0;
    for (int g = 0; g < GROUPS; g++) begin
      bad = bad | (^{w.data[g*GROUP_W +: GROUP_W], w.check[g]});
    end
    return bad;
  endfunction

endpackage

// ==== dbi_link_if.sv ====
/*
  The shared bus lines between the processor end and the chipset end.
  Assumes every line is pulled high when undriven; drivers only pull low
  where their enable is low, so the level is a wired AND.
*/
interface dbi_link_if;
  import dbi_pkg::*;

  logic       link_clk;
  wire_word_t proc_word;
  wire_word_t chip_word;
  wire_word_t word_line;
  logic       proc_word_oe_b;
  logic       chip_word_oe_b;
  logic       proc_occ_out;
  logic       proc_occ_oe_b;
  logic       chip_occ_out;
  logic       chip_occ_oe_b;
  logic       occ_line;
  logic       chip_post_out;
  logic       chip_post_oe_b;
  logic       post_line;

  assign word_line = (proc_word_oe_b ? '1 : proc_word) & (chip_word_oe_b ? '1 : chip_word);
  assign occ_line  = (proc_occ_oe_b | proc_occ_out) & (chip_occ_oe_b | chip_occ_out);
  assign post_line = chip_post_oe_b | chip_post_out;

  modport proc (
    input  link_clk, word_line, occ_line, post_line,
    output proc_word, proc_word_oe_b, proc_occ_out, proc_occ_oe_b
  );

  modport chip (
    input  word_line, occ_line,
    output link_clk, chip_word, chip_word_oe_b, chip_occ_out, chip_occ_oe_b,
    output chip_post_out, chip_post_oe_b
  );

endinterface

// ==== bus_proc_end.sv ====
/*
  Processor end of the data phase, clocked by the link clock alone.
  Assumes the chipset launches its lines on the falling link edge, so every
  line is read directly on the rising edge without synchronisers.
*/
module bus_proc_end
  import dbi_pkg::*;
(
  input  wire logic              rst_b_in,
  dbi_link_if.proc               link,
  input  wire logic              tx_valid_in,
  input  wire logic [LINE_W-1:0] tx_line_in,
  output logic                   tx_ready_out,
  output logic [LINE_W-1:0]      rx_line_out,
  output logic                   rx_valid_out,
  output logic                   rx_check_err_out,
  output logic                   postponed_out
);

  xfer_state_t       st_q;
  logic [1:0]        beat_q;
  logic              pend_q;
  logic              ready_q;
  logic [LINE_W-1:0] tx_buf_q;
  wire_word_t        word_q;
  logic              word_oe_b_q;
  logic              occ_oe_b_q;
  logic [1:0]        rx_beat_q;
  logic [LINE_W-1:0] rx_buf_q;
  logic              rx_err_q;
  logic [LINE_W-1:0] rx_line_q;
  logic              rx_valid_q;
  logic              rx_check_err_q;
  logic              post_q;
  logic              accept;
  logic              claim;
  logic              take;
  logic              beat_err;

  assign accept   = tx_valid_in && ready_q;
  assign claim    = (st_q == ST_IDLE) && pend_q && link.occ_line;   // [RL8]
  assign take     = (link.occ_line == LINE_LOW) && (st_q != ST_DRIVE);
  assign beat_err = check_fail(link.word_line);

  always_ff @(posedge link.link_clk or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q   <= ST_IDLE;
      beat_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (claim) begin
            st_q   <= ST_DRIVE;
            beat_q <= '0;
          end
        end
        ST_DRIVE: begin
          if (beat_q == BEAT_LAST) begin   // [RL12]
            st_q <= ST_RELEASE;
          end else begin
            beat_q <= beat_q + 2'h1;
          end
        end
        ST_RELEASE: st_q <= ST_IDLE;
        default:    st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge link.link_clk or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_q <= 1'b1;
      pend_q  <= 1'b0;
    end else begin
      if (accept) begin
        ready_q <= 1'b0;
        pend_q  <= 1'b1;
      end else if (claim) begin
        pend_q <= 1'b0;
      end
      if (st_q == ST_RELEASE) begin
        ready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge link.link_clk or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_buf_q <= '0;
    end else if (accept) begin
      tx_buf_q <= tx_line_in;
    end else if (claim || (st_q == ST_DRIVE)) begin
      tx_buf_q <= tx_buf_q >> DATA_W;
    end
  end

  // data, flags, check bits and occupied all move on the same edge
  always_ff @(posedge link.link_clk or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_q      <= '1;
      word_oe_b_q <= 1'b1;
      occ_oe_b_q  <= 1'b1;
    end else if (claim || ((st_q == ST_DRIVE) && (beat_q != BEAT_LAST))) begin
      word_q      <= encode_word(tx_buf_q[DATA_W-1:0]);   // [RL1] [RL6] [RL11]
      word_oe_b_q <= 1'b0;
      occ_oe_b_q  <= 1'b0;                                // [RL7]
    end else if (st_q == ST_DRIVE) begin
      word_q      <= '1;
      word_oe_b_q <= 1'b1;
      occ_oe_b_q  <= 1'b1;
    end
  end

  always_ff @(posedge link.link_clk or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_beat_q      <= '0;
      rx_buf_q       <= '0;
      rx_err_q       <= 1'b0;
      rx_line_q      <= '0;
      rx_valid_q     <= 1'b0;
      rx_check_err_q <= 1'b0;
      post_q         <= 1'b0;
    end else begin
      rx_valid_q <= take && (rx_beat_q == BEAT_LAST);
      post_q     <= (link.post_line == LINE_LOW);         // [RL9]
      if (take) begin
        rx_buf_q  <= {decode_word(link.word_line), rx_buf_q[LINE_W-1:DATA_W]};   // [RL3]
        rx_beat_q <= rx_beat_q + 2'h1;
        rx_err_q  <= ((rx_beat_q == '0) ? 1'b0 : rx_err_q) | beat_err;
        if (rx_beat_q == BEAT_LAST) begin
          rx_line_q      <= {decode_word(link.word_line), rx_buf_q[LINE_W-1:DATA_W]};
          rx_check_err_q <= rx_err_q | beat_err;
        end
      end else if (link.occ_line != LINE_LOW) begin
        rx_beat_q <= '0;
      end
    end
  end

  assign link.proc_word      = word_q;
  assign link.proc_word_oe_b = word_oe_b_q;
  assign link.proc_occ_out   = LINE_LOW;
  assign link.proc_occ_oe_b  = occ_oe_b_q;
  assign tx_ready_out        = ready_q;
  assign rx_line_out         = rx_line_q;
  assign rx_valid_out        = rx_valid_q;
  assign rx_check_err_out    = rx_check_err_q;
  assign postponed_out       = post_q;

endmodule

// ==== bus_chip_end.sv ====
/*
  Chipset end of the data phase: makes the link clock by dividing its own
  clock, and runs all bus logic on that same clock.
  Assumes the processor end launches on the rising link edge; lines coming
  back pass two flip-flops and are read at the falling-edge launch point.
*/
module bus_chip_end
  import dbi_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_b_in,
  dbi_link_if.chip               link,
  input  wire logic              tx_valid_in,
  input  wire logic [LINE_W-1:0] tx_line_in,
  input  wire logic              postpone_in,
  output logic                   tx_ready_out,
  output logic [LINE_W-1:0]      rx_line_out,
  output logic                   rx_valid_out,
  output logic                   rx_check_err_out
);

  logic [3:0]        div_q;
  logic              link_clk_q;
  logic [WIRE_W:0]   pins;
  logic [WIRE_W:0]   sync1_q;
  logic [WIRE_W:0]   sync2_q;
  wire_word_t        word_s;
  logic              occ_s;
  logic              tick;

  xfer_state_t       st_q;
  logic [1:0]        beat_q;
  logic              pend_q;
  logic              ready_q;
  logic [LINE_W-1:0] tx_buf_q;
  wire_word_t        word_q;
  logic              word_oe_b_q;
  logic              occ_oe_b_q;
  logic              post_oe_b_q;

  logic [1:0]        rx_beat_q;
  logic [LINE_W-1:0] rx_buf_q;
  logic              rx_err_q;
  logic [LINE_W-1:0] rx_line_q;
  logic              rx_valid_q;
  logic              rx_check_err_q;

  logic              accept;
  logic              claim;
  logic              take;
  logic              last_take;
  logic              beat_err;

  // the link clock is a plain divided register; it runs from reset onward
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q      <= '0;
      link_clk_q <= 1'b0;
    end else begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + 4'h1;
      if (div_q == DIV_LAST) begin
        link_clk_q <= 1'b1;
      end else if (div_q == DIV_FALL) begin
        link_clk_q <= 1'b0;
      end
    end
  end

  // launch on the falling link edge; the processor reads on the rising one
  assign tick = (div_q == LAUNCH_CNT);

  assign pins = {link.word_line, link.occ_line};

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // the synchronised view at the tick is about two cycles old, which is
  // still after the processor's rising-edge launch in the same link period;
  // that ordering is what keeps the two claims from colliding
  assign {word_s, occ_s} = sync2_q;

  assign accept    = tx_valid_in && ready_q;
  assign claim     = tick && (st_q == ST_IDLE) && pend_q && (occ_s != LINE_LOW);  // [RL8]
  assign take      = tick && (occ_s == LINE_LOW) && (st_q != ST_DRIVE);
  assign last_take = take && (rx_beat_q == BEAT_LAST);
  assign beat_err  = check_fail(word_s);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q   <= ST_IDLE;
      beat_q <= '0;
    end else if (tick) begin
      unique case (st_q)
        ST_IDLE: begin
          if (claim) begin
            st_q   <= ST_DRIVE;
            beat_q <= '0;
          end
        end
        ST_DRIVE: begin
          if (beat_q == BEAT_LAST) begin   // [RL12]
            st_q <= ST_RELEASE;
          end else begin
            beat_q <= beat_q + 2'h1;
          end
        end
        ST_RELEASE: st_q <= ST_IDLE;
        default:    st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_q <= 1'b1;
      pend_q  <= 1'b0;
    end else begin
      if (accept) begin
        ready_q <= 1'b0;
        pend_q  <= 1'b1;
      end else if (claim) begin
        pend_q <= 1'b0;
      end
      if (tick && (st_q == ST_RELEASE)) begin
        ready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_buf_q <= '0;
    end else if (accept) begin
      tx_buf_q <= tx_line_in;
    end else if (claim || (tick && (st_q == ST_DRIVE))) begin
      tx_buf_q <= tx_buf_q >> DATA_W;
    end
  end

  // a burst owns the bus for exactly four link periods, then lets go
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_q      <= '1;
      word_oe_b_q <= 1'b1;
      occ_oe_b_q  <= 1'b1;
    end else if (claim || (tick && (st_q == ST_DRIVE) && (beat_q != BEAT_LAST))) begin
      word_q      <= encode_word(tx_buf_q[DATA_W-1:0]);   // [RL1] [RL4] [RL6] [RL11]
      word_oe_b_q <= 1'b0;
      occ_oe_b_q  <= 1'b0;                                // [RL7]
    end else if (tick && (st_q == ST_DRIVE)) begin
      word_q      <= '1;
      word_oe_b_q <= 1'b1;
      occ_oe_b_q  <= 1'b1;
    end
  end

  // postpone answers the line just taken from the processor, for one link
  // period; postpone_in is only looked at on that last beat
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      post_oe_b_q <= 1'b1;
    end else if (tick) begin
      post_oe_b_q <= !(last_take && postpone_in);          // [RL9] [RL10]
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_beat_q      <= '0;
      rx_buf_q       <= '0;
      rx_err_q       <= 1'b0;
      rx_line_q      <= '0;
      rx_valid_q     <= 1'b0;
      rx_check_err_q <= 1'b0;
    end else begin
      rx_valid_q <= last_take;
      if (take) begin
        rx_buf_q  <= {decode_word(word_s), rx_buf_q[LINE_W-1:DATA_W]};   // [RL2] [RL3]
        rx_beat_q <= rx_beat_q + 2'h1;
        rx_err_q  <= ((rx_beat_q == '0) ? 1'b0 : rx_err_q) | beat_err;
        if (rx_beat_q == BEAT_LAST) begin
          rx_line_q      <= {decode_word(word_s), rx_buf_q[LINE_W-1:DATA_W]};
          rx_check_err_q <= rx_err_q | beat_err;
        end
      end else if (tick && (occ_s != LINE_LOW)) begin
        rx_beat_q <= '0;
      end
    end
  end

  assign link.link_clk       = link_clk_q;
  assign link.chip_word      = word_q;
  assign link.chip_word_oe_b = word_oe_b_q;
  assign link.chip_occ_out   = LINE_LOW;
  assign link.chip_occ_oe_b  = occ_oe_b_q;
  assign link.chip_post_out  = LINE_LOW;
  assign link.chip_post_oe_b = post_oe_b_q;
  assign tx_ready_out        = ready_q;
  assign rx_line_out         = rx_line_q;
  assign rx_valid_out        = rx_valid_q;
  assign rx_check_err_out    = rx_check_err_q;

endmodule

// ==== dbi_link_chk.sv ====
/*
  Checker on the shared lines of dbi_link_if, sampled on rising link edges.
  Assumes the bench hands it the interface signals and the active-low reset.
*/
module dbi_link_chk
  import dbi_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       rst_b_in,
  input  wire wire_word_t word_line,
  input  wire logic       proc_word_oe_b,
  input  wire logic       chip_word_oe_b,
  input  wire logic       proc_occ_oe_b,
  input  wire logic       chip_occ_oe_b,
  input  wire logic       occ_line,
  input  wire logic       post_line
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_b_in);

  logic drv;
  assign drv = !(proc_word_oe_b && chip_word_oe_b);

  AST_PROC_OCC: assert property (proc_word_oe_b == proc_occ_oe_b)
    else $error("proc data enable and occupied differ");
  AST_CHIP_OCC: assert property (chip_word_oe_b == chip_occ_oe_b)
    else $error("chip data enable and occupied differ");
  AST_PROC_CLAIM: assert property ($fell(proc_word_oe_b) |-> $past(occ_line))
    else $error("proc claimed an occupied bus");
  // the chip claims half a period after a rising-edge release, so the shared line
  // sampled one edge earlier can still show the old owner; look for overlap instead
  AST_CHIP_CLAIM: assert property ($fell(chip_word_oe_b) |-> proc_occ_oe_b)
    else $error("chip claimed an occupied bus");
  // per-end enables, since a chip owner right after the processor keeps the shared line low throughout
  AST_BURST: assert property (
    $fell(proc_occ_oe_b) |-> !proc_occ_oe_b [*4] ##1 proc_occ_oe_b)
    else $error("proc burst is not four sub-phases");
  AST_CHIP_BURST: assert property (
    $fell(chip_occ_oe_b) |-> !chip_occ_oe_b [*4] ##1 chip_occ_oe_b)
    else $error("chip burst is not four sub-phases");
  AST_POST_ONE: assert property ($fell(post_line) |-> ##1 post_line)
    else $error("postpone held longer than one period");
  AST_POST_ADDR: assert property ($fell(post_line) |-> !proc_occ_oe_b)
    else $error("postpone outside a processor line");

  for (genvar g = 0; g < GROUPS; g++) begin : grp
    logic [GROUP_W-1:0] d;
    assign d = word_line.data[g*GROUP_W +: GROUP_W];
    AST_LOWS: assert property (drv |-> $countones(~d) <= 8)
      else $error("group driven with more than half low");
    AST_FLAG: assert property (drv && !word_line.flags[g] |-> $countones(~d) < 8)
      else $error("group inverted without cause");
    AST_CHECK: assert property (drv |-> !(^{d, word_line.check[g]}))
      else $error("check bit does not match group");
  end
endmodule

// ==== test_system_bus_data_inversion.sv ====
/*
  Bench joining the processor end and the chipset end through dbi_link_if.
  Assumes the package, interface, both ends and the checker compile first.
*/
module test_system_bus_data_inversion
  import dbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              ref_clk, rst_b, p_valid, c_valid, post_in;
  logic              p_ready, c_ready, p_rx_v, c_rx_v, p_err, c_err, p_post;
  logic [LINE_W-1:0] p_line, c_line, p_rx, c_rx;
  logic [LINE_W-1:0] q_c[$], q_p[$];
  logic              q_post[$];
  int                num_errors, checks_done, cyc, n;
  logic [15:0]       pat[5] = '{16'h00FF, 16'h01FF, 16'hFFFF, 16'h0000, 16'h7F00};

  dbi_link_if link_if();

  bus_proc_end bus_proc_end_inst (.rst_b_in(rst_b), .link(link_if), .tx_valid_in(p_valid),
    .tx_line_in(p_line), .tx_ready_out(p_ready), .rx_line_out(p_rx), .rx_valid_out(p_rx_v),
    .rx_check_err_out(p_err), .postponed_out(p_post));
  bus_chip_end bus_chip_end_inst (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .link(link_if),
    .tx_valid_in(c_valid), .tx_line_in(c_line), .postpone_in(post_in), .tx_ready_out(c_ready),
    .rx_line_out(c_rx), .rx_valid_out(c_rx_v), .rx_check_err_out(c_err));
  dbi_link_chk dbi_link_chk_inst (.link_clk(link_if.link_clk), .rst_b_in(rst_b),
    .word_line(link_if.word_line), .proc_word_oe_b(link_if.proc_word_oe_b),
    .chip_word_oe_b(link_if.chip_word_oe_b), .proc_occ_oe_b(link_if.proc_occ_oe_b),
    .chip_occ_oe_b(link_if.chip_occ_oe_b), .occ_line(link_if.occ_line),
    .post_line(link_if.post_line));

  always #5 ref_clk = ~ref_clk;

  task automatic cmp_line(input logic [LINE_W-1:0] got, exp, input logic err);
    checks_done++;
    if (got !== exp || err !== 1'b0) begin
      num_errors++;
      $display("unexpected at %0t: line %h err %b", $time, got, err);
    end
  endtask

  task automatic cmp_bit(input logic got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // each group position meets every boundary pattern across the five seeds
  function automatic logic [LINE_W-1:0] mk(input int s);
    logic [LINE_W-1:0] l;
    for (int k = 0; k < 16; k++) l[k*16 +: 16] = pat[(s + k) % 5];
    return l;
  endfunction

  function automatic logic [LINE_W-1:0] rnd();
    logic [LINE_W-1:0] l;
    for (int k = 0; k < 8; k++) l[k*32 +: 32] = $urandom();
    return l;
  endfunction

  task automatic p_send(input logic [LINE_W-1:0] l, input logic pp);
    int w;
    w = 0;
    @(posedge link_if.link_clk);
    while (p_ready !== 1'b1 && w < 50) begin
      @(posedge link_if.link_clk);
      w++;
    end
    q_c.push_back(l);
    if (pp) q_post.push_back(1'b1);
    p_valid <= 1'b1;
    p_line  <= l;
    post_in <= pp;
    @(posedge link_if.link_clk);
    p_valid <= 1'b0;
  endtask

  task automatic c_send(input logic [LINE_W-1:0] l);
    int w;
    w = 0;
    @(posedge ref_clk);
    while (c_ready !== 1'b1 && w < 400) begin
      @(posedge ref_clk);
      w++;
    end
    q_p.push_back(l);
    c_valid <= 1'b1;
    c_line  <= l;
    @(posedge ref_clk);
    c_valid <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    if (c_rx_v === 1'b1) begin
      if (q_c.size() == 0) cmp_bit(1'b1, 1'b0);
      else cmp_line(c_rx, q_c.pop_front(), c_err);
    end
  end

  always @(posedge link_if.link_clk) begin
    if (p_rx_v === 1'b1) begin
      if (q_p.size() == 0) cmp_bit(1'b1, 1'b0);
      else cmp_line(p_rx, q_p.pop_front(), p_err);
    end
    if (p_post === 1'b1) begin
      if (q_post.size() == 0) cmp_bit(1'b1, 1'b0);
      else cmp_bit(1'b1, q_post.pop_front());
    end
  end

  // ceiling is several times the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      wrap_up();
    end
  end

  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b1;
    p_valid = 1'b0;
    c_valid = 1'b0;
    post_in = 1'b0;
    p_line = '0;
    c_line = '0;
    num_errors = 0;
    checks_done = 0;
    cyc = 0;
    void'($urandom(32'hF7BCCDE5));
    // the link clock stays low in reset, so the processor end needs a real falling edge
    #1 rst_b = 1'b0;
    repeat (5) @(posedge ref_clk);
    // release away from edges, no release synchroniser in the ends
    @(negedge ref_clk) rst_b = 1'b1;
    for (int s = 0; s < 5; s++) p_send(mk(s), 1'(s));
    $display("test 1 done: processor to chipset, boundary groups");
    for (int s = 0; s < 9; s++) c_send(s < 5 ? mk(s) : rnd());
    $display("test 2 done: chipset to processor");
    for (int s = 0; s < 6; s++) begin
      fork
        p_send(rnd(), 1'b0);
        c_send(rnd());
      join
    end
    $display("test 3 done: both directions contending");
    n = 0;
    while ((q_c.size() + q_p.size() + q_post.size()) != 0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    cmp_bit(1'((q_c.size() + q_p.size() + q_post.size()) == 0), 1'b1);
    wrap_up();
  end
endmodule
